// File: hdl/asfu_flags_top.v
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/10ps
`include "asfu_consts.vh"

module asfu_flags_top (
  input wire clk_sys_i,
  input wire reset_i,
  // apb slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  // operation strobes; pe select 0 = x, 1 = y
  input wire op_pe_i,
  input wire mul_op_i,
  input wire mul_float_i,
  input wire mul_nan_i,
  input wire mul_inf_zero_i,
  input wire alu_op_i,
  input wire alu_float_i,
  input wire alu_cmp_i,
  input wire alu_cmp_x_gt_i,
  input wire sh_op_i,
  input wire [2:0] sh_kind_i,
  input wire [31:0] sh_in_i,
  input wire [31:0] sh_result_i,
  input wire sh_lost_bits_i,
  input wire [7:0] sh_pos_i,
  input wire [7:0] sh_len_i,
  input wire [5:0] sh_lead_cnt_i,
  input wire bt_op_i,
  input wire [31:0] bt_sysreg_i,
  input wire [31:0] bt_value_i,
  output wire [31:0] pe_x_arith_status_o,
  output wire [31:0] pe_y_arith_status_o,
  output wire mult_invalid_sticky_x_o,
  output wire mult_invalid_sticky_y_o
);

  // shifter operation kinds
  localparam [2:0] SH_SHIFT = 3'h0;
  localparam [2:0] SH_BIT_TEST = 3'h1;
  localparam [2:0] SH_BIT_MOD = 3'h2;
  localparam [2:0] SH_EXTRACT = 3'h3;
  localparam [2:0] SH_LEAD_CNT = 3'h4;

  // apb access states, one-hot
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_ACCESS = 2'b10;

  // positions in the one-hot register select
  localparam SEL_STAT_X = 0;
  localparam SEL_STAT_Y = 1;
  localparam SEL_STKY_X = 2;
  localparam SEL_STKY_Y = 3;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [31:0] prdata_r;
  reg [31:0] prdata_nxt;
  reg sh_ovf;
  reg sh_zero;
  wire addr_ok;
  wire wr_en;
  wire rd_en;
  wire bt_match;
  wire [31:0] stat_x;
  wire [31:0] stat_y;
  wire sticky_x;
  wire sticky_y;
  wire [3:0] reg_sel;
  wire wr_stat_x;
  wire wr_stat_y;
  wire wr_stky_x;
  wire wr_stky_y;
  wire [31:0] wr_stat_data;
  wire wr_stky_bit;
  wire mul_op_x;
  wire mul_op_y;
  wire alu_op_x;
  wire alu_op_y;
  wire sh_op_x;
  wire sh_op_y;
  wire bt_op_x;
  wire bt_op_y;
  wire sh_sign;

  // bit position beyond the 32-bit fixed-point field
  function out_of_field;
    input [7:0] pos;
    begin
      out_of_field = (pos >= 8'd`ASFU_FIELD_W);
    end
  endfunction

  // one-hot decode of the four mapped words; zero for any other address
  function [3:0] decode_reg;
    input [11:0] addr;
    begin
      decode_reg = 4'h0;
      case (addr)
        `ASFU_OFF_PE_X_STATUS: decode_reg = 4'b0001;
        `ASFU_OFF_PE_Y_STATUS: decode_reg = 4'b0010;
        `ASFU_OFF_STICKY_X: decode_reg = 4'b0100;
        `ASFU_OFF_STICKY_Y: decode_reg = 4'b1000;
        default: decode_reg = 4'h0;
      endcase
    end
  endfunction

  // sticky word as software sees it: only the invalid sticky bit is live
  function [31:0] sticky_word;
    input bit_val;
    begin
      sticky_word = 32'h0000_0000;
      sticky_word[`ASFU_BIT_MULT_INV_STICKY] = bit_val;
    end
  endfunction

  // extract reaches past or across the left edge; nine bits avoid wrap
  function extract_past_edge;
    input [7:0] pos;
    input [7:0] len;
    reg [8:0] top;
    begin
      top = {1'b0, pos} + {1'b0, len};
      extract_past_edge = (top > 9'd`ASFU_FIELD_W);
    end
  endfunction

  // leading zero or one count that spans the whole field
  function lead_full;
    input [5:0] cnt;
    begin
      lead_full = (cnt == 6'd`ASFU_FIELD_W);
    end
  endfunction

  // shifter flag decode; straddling extract uses pos + len > 32
  always @* begin
    sh_ovf = 1'b0;
    sh_zero = (sh_result_i == 32'h0000_0000);
    case (sh_kind_i)
      SH_SHIFT: begin
        sh_ovf = sh_lost_bits_i;
      end
      SH_BIT_TEST: begin
        sh_ovf = out_of_field(sh_pos_i);
        if (out_of_field(sh_pos_i)) begin
          sh_zero = 1'b1;
        end
      end
      SH_BIT_MOD: begin
        sh_ovf = out_of_field(sh_pos_i);
      end
      SH_EXTRACT: begin
        sh_ovf = extract_past_edge(sh_pos_i, sh_len_i);
      end
      SH_LEAD_CNT: begin
        sh_ovf = lead_full(sh_lead_cnt_i);
      end
      default: begin
        sh_ovf = 1'b0;
      end
    endcase
  end

  // bit test and bit xor both compare selected bits against the value
  assign bt_match = ((bt_sysreg_i & bt_value_i) == bt_value_i);

  // route each strobe to the processing element it names
  assign mul_op_x = mul_op_i & ~op_pe_i;
  assign mul_op_y = mul_op_i & op_pe_i;
  assign alu_op_x = alu_op_i & ~op_pe_i;
  assign alu_op_y = alu_op_i & op_pe_i;
  assign sh_op_x = sh_op_i & ~op_pe_i;
  assign sh_op_y = sh_op_i & op_pe_i;
  assign bt_op_x = bt_op_i & ~op_pe_i;
  assign bt_op_y = bt_op_i & op_pe_i;
  assign sh_sign = sh_in_i[31];

  asfu_pe_flags u_pe_x (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .mul_op_i(mul_op_x),
    .mul_float_i(mul_float_i),
    .mul_nan_i(mul_nan_i),
    .mul_inf_zero_i(mul_inf_zero_i),
    .alu_op_i(alu_op_x),
    .alu_float_i(alu_float_i),
    .alu_cmp_i(alu_cmp_i),
    .alu_cmp_x_gt_i(alu_cmp_x_gt_i),
    .sh_op_i(sh_op_x),
    .sh_ovf_i(sh_ovf),
    .sh_zero_i(sh_zero),
    .sh_sign_i(sh_sign),
    .bt_op_i(bt_op_x),
    .bt_match_i(bt_match),
    .wr_status_i(wr_stat_x),
    .wr_data_i(wr_stat_data),
    .wr_sticky_i(wr_stky_x),
    .wr_sticky_val_i(wr_stky_bit),
    .status_o(stat_x),
    .sticky_o(sticky_x)
  );

  asfu_pe_flags u_pe_y (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .mul_op_i(mul_op_y),
    .mul_float_i(mul_float_i),
    .mul_nan_i(mul_nan_i),
    .mul_inf_zero_i(mul_inf_zero_i),
    .alu_op_i(alu_op_y),
    .alu_float_i(alu_float_i),
    .alu_cmp_i(alu_cmp_i),
    .alu_cmp_x_gt_i(alu_cmp_x_gt_i),
    .sh_op_i(sh_op_y),
    .sh_ovf_i(sh_ovf),
    .sh_zero_i(sh_zero),
    .sh_sign_i(sh_sign),
    .bt_op_i(bt_op_y),
    .bt_match_i(bt_match),
    .wr_status_i(wr_stat_y),
    .wr_data_i(wr_stat_data),
    .wr_sticky_i(wr_stky_y),
    .wr_sticky_val_i(wr_stky_bit),
    .status_o(stat_y),
    .sticky_o(sticky_y)
  );

  assign pe_x_arith_status_o = stat_x;
  assign pe_y_arith_status_o = stat_y;
  assign mult_invalid_sticky_x_o = sticky_x;
  assign mult_invalid_sticky_y_o = sticky_y;

  // software write strobes; reserved bits are masked before the flag logic
  assign reg_sel = decode_reg(paddr_i);
  assign wr_stat_x = wr_en & reg_sel[SEL_STAT_X];
  assign wr_stat_y = wr_en & reg_sel[SEL_STAT_Y];
  assign wr_stky_x = wr_en & reg_sel[SEL_STKY_X];
  assign wr_stky_y = wr_en & reg_sel[SEL_STKY_Y];
  assign wr_stat_data = pwdata_i & `ASFU_STATUS_WMASK;
  assign wr_stky_bit = pwdata_i[`ASFU_BIT_MULT_INV_STICKY];
  assign addr_ok = |reg_sel;
  // a transfer completes in the first access cycle
  assign wr_en = psel_i & penable_i & pwrite_i & (state_r == ST_ACCESS);
  assign rd_en = psel_i & ~penable_i & ~pwrite_i;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~addr_ok;
  assign prdata_o = prdata_r;

  always @* begin
    state_nxt = ST_IDLE;
    case (state_r)
      ST_IDLE: if (psel_i && !penable_i) begin
        state_nxt = ST_ACCESS;
      end
      ST_ACCESS: if (psel_i && !penable_i) begin
        state_nxt = ST_ACCESS;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // read data captured in setup so it is stable through the access cycle
  always @* begin
    prdata_nxt = prdata_r;
    if (rd_en) begin
      case (paddr_i)
        `ASFU_OFF_PE_X_STATUS: prdata_nxt = stat_x;
        `ASFU_OFF_PE_Y_STATUS: prdata_nxt = stat_y;
        `ASFU_OFF_STICKY_X: prdata_nxt = sticky_word(sticky_x);
        `ASFU_OFF_STICKY_Y: prdata_nxt = sticky_word(sticky_y);
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_r <= ST_IDLE;
      prdata_r <= `ASFU_STATUS_RESET;
    end else begin
      state_r <= state_nxt;
      prdata_r <= prdata_nxt;
    end
  end

endmodule

// File: hdl/asfu_consts.vh
`ifndef ASFU_CONSTS_VH
`define ASFU_CONSTS_VH

// apb byte offsets
`define ASFU_OFF_PE_X_STATUS 12'h000
`define ASFU_OFF_PE_Y_STATUS 12'h004
`define ASFU_OFF_STICKY_X 12'h008
`define ASFU_OFF_STICKY_Y 12'h00c

// status field positions
`define ASFU_BIT_MULT_INVALID 9
`define ASFU_BIT_ALU_FLOAT 10
`define ASFU_BIT_SHIFT_OVF 11
`define ASFU_BIT_SHIFT_ZERO 12
`define ASFU_BIT_SHIFT_SIGN 13
`define ASFU_BIT_BIT_TEST 18
`define ASFU_CMP_HI 31
`define ASFU_CMP_LO 24

// sticky register position of the multiplier invalid sticky bit
`define ASFU_BIT_MULT_INV_STICKY 9

// writable bits of the upper status half: 9..13, 18, 31..24
`define ASFU_STATUS_WMASK 32'hff04_3e00

// reset values
`define ASFU_STATUS_RESET 32'h0000_0000
`define ASFU_STICKY_RESET 1'b0

// fixed-point field width
`define ASFU_FIELD_W 32
`define ASFU_FIELD_W_LOG 6

`endif

// File: hdl/asfu_pe_flags.v
`timescale 1ns/10ps
`include "asfu_consts.vh"

// flag state of one processing element
module asfu_pe_flags (
  input wire clk_sys_i,
  input wire reset_i,
  input wire mul_op_i,
  input wire mul_float_i,
  input wire mul_nan_i,
  input wire mul_inf_zero_i,
  input wire alu_op_i,
  input wire alu_float_i,
  input wire alu_cmp_i,
  input wire alu_cmp_x_gt_i,
  input wire sh_op_i,
  input wire sh_ovf_i,
  input wire sh_zero_i,
  input wire sh_sign_i,
  input wire bt_op_i,
  input wire bt_match_i,
  input wire wr_status_i,
  input wire [31:0] wr_data_i,
  input wire wr_sticky_i,
  input wire wr_sticky_val_i,
  output wire [31:0] status_o,
  output reg sticky_o
);

  reg mi_r;
  reg af_r;
  reg sv_r;
  reg sz_r;
  reg ss_r;
  reg bt_r;
  reg [7:0] cmp_r;
  wire mi_set;

  assign mi_set = mul_op_i & mul_float_i & (mul_nan_i | mul_inf_zero_i);

  // reserved ranges are hard zeros
  assign status_o = {cmp_r, 4'h0, 1'b0, bt_r, 4'h0,
                     ss_r, sz_r, sv_r, af_r, mi_r, 9'h000};

  // hardware update has priority over a software write in the same cycle
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      mi_r <= 1'b0;
      af_r <= 1'b0;
      sv_r <= 1'b0;
      sz_r <= 1'b0;
      ss_r <= 1'b0;
      bt_r <= 1'b0;
      cmp_r <= 8'h00;
    end else begin
      if (mul_op_i && mul_float_i) begin
        mi_r <= mi_set;
      end else if (wr_status_i) begin
        mi_r <= wr_data_i[`ASFU_BIT_MULT_INVALID];
      end
      if (alu_op_i) begin
        af_r <= alu_float_i;
      end else if (wr_status_i) begin
        af_r <= wr_data_i[`ASFU_BIT_ALU_FLOAT];
      end
      if (sh_op_i) begin
        sv_r <= sh_ovf_i;
        sz_r <= sh_zero_i;
        ss_r <= sh_sign_i;
      end else if (wr_status_i) begin
        sv_r <= wr_data_i[`ASFU_BIT_SHIFT_OVF];
        sz_r <= wr_data_i[`ASFU_BIT_SHIFT_ZERO];
        ss_r <= wr_data_i[`ASFU_BIT_SHIFT_SIGN];
      end
      if (bt_op_i) begin
        bt_r <= bt_match_i;
      end else if (wr_status_i) begin
        bt_r <= wr_data_i[`ASFU_BIT_BIT_TEST];
      end
      if (alu_op_i && alu_cmp_i) begin
        cmp_r <= {alu_cmp_x_gt_i, cmp_r[7:1]};
      end else if (wr_status_i) begin
        cmp_r <= wr_data_i[`ASFU_CMP_HI:`ASFU_CMP_LO];
      end
    end
  end

  // set wins over a clearing write
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      sticky_o <= `ASFU_STICKY_RESET;
    end else if (mi_set) begin
      sticky_o <= 1'b1;
    end else if (wr_sticky_i) begin
      sticky_o <= wr_sticky_val_i;
    end
  end

endmodule

// File: verification/asfu_flags_sva.sv
`timescale 1ns/10ps
module asfu_flags_sva (
  input wire clk_sys_i,
  input wire reset_i,
  input wire op_pe_i,
  input wire mul_op_i,
  input wire mul_float_i,
  input wire mul_nan_i,
  input wire mul_inf_zero_i,
  input wire alu_op_i,
  input wire alu_float_i,
  input wire alu_cmp_i,
  input wire alu_cmp_x_gt_i,
  input wire sh_op_i,
  input wire [2:0] sh_kind_i,
  input wire [31:0] sh_in_i,
  input wire [7:0] sh_pos_i,
  input wire [31:0] pe_x_arith_status_o,
  input wire mult_invalid_sticky_x_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  wire [31:0] st = pe_x_arith_status_o;
  wire mx = mul_op_i && mul_float_i && !op_pe_i;
  wire bad = mul_nan_i || mul_inf_zero_i;
  wire sx = sh_op_i && !op_pe_i;
  wire ax = alu_op_i && !op_pe_i;
  // bit ops past bit 31 must flag overflow
  wire out = sx && sh_pos_i > 8'h1f;
  property p_mi; mx |=> st[9] == $past(bad); endproperty
  a_mi: assert property (p_mi) else $error("invalid flag");
  property p_mis; mx && bad |=> mult_invalid_sticky_x_o; endproperty
  a_mis: assert property (p_mis) else $error("invalid sticky");
  property p_af; ax |=> st[10] == $past(alu_float_i); endproperty
  a_af: assert property (p_af) else $error("alu float flag");
  property p_ss; sx |=> st[13] == $past(sh_in_i[31]); endproperty
  a_ss: assert property (p_ss) else $error("shift sign");
  property p_sv; out && sh_kind_i inside {3'h1, 3'h2} |=> st[11]; endproperty
  a_sv: assert property (p_sv) else $error("shift overflow");
  property p_sz; out && sh_kind_i == 3'h1 |=> st[12]; endproperty
  a_sz: assert property (p_sz) else $error("shift zero");
  property p_ca;
    ax && alu_cmp_i |=> st[31:24] == {$past(alu_cmp_x_gt_i), $past(st[31:25])};
  endproperty
  a_ca: assert property (p_ca) else $error("compare history");
  property p_rs; st[17:14] == 4'h0 && st[23:19] == 5'h0; endproperty
  a_rs: assert property (p_rs) else $error("reserved bits");
endmodule

// File: verification/test_arith_status_flags_upper.sv
`timescale 1ns/10ps
module test_arith_status_flags_upper;
  logic clk_sys_i = 0, reset_i = 1, psel_i = 0, penable_i = 0;
  logic pwrite_i = 0, op_pe_i = 0, mul_op_i = 0, mul_float_i = 0;
  logic mul_nan_i = 0, mul_inf_zero_i = 0, alu_op_i = 0, alu_float_i = 0;
  logic alu_cmp_i = 0, alu_cmp_x_gt_i = 0, sh_op_i = 0, sh_lost_bits_i = 0;
  logic bt_op_i = 0, er;
  logic [2:0] sh_kind_i = 0;
  logic [5:0] sh_lead_cnt_i = 0;
  logic [7:0] sh_pos_i = 0, sh_len_i = 0;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, sh_in_i = 0, sh_result_i = 0, rd;
  logic [31:0] bt_sysreg_i = 0, bt_value_i = 0;
  wire [31:0] prdata_o, pe_x_arith_status_o, pe_y_arith_status_o;
  wire pready_o, pslverr_o, mult_invalid_sticky_x_o, mult_invalid_sticky_y_o;
  wire [31:0] sx = pe_x_arith_status_o;
  int errors = 0, checks_done = 0;
  asfu_flags_top uut (.*);
  always #2 clk_sys_i = ~clk_sys_i;
  task check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task final_report;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    if (pready_o !== 1'b1) begin
      errors++;
      final_report;
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
    #1;
  endtask
  // strobes are single-cycle; flags are judged once the edge has landed
  task go;
    @(posedge clk_sys_i);
    mul_op_i <= 0;
    alu_op_i <= 0;
    sh_op_i <= 0;
    bt_op_i <= 0;
    #1;
  endtask
  task t_reg;
    apb(0, 12'h000, 0);
    check(rd, 32'h0);
    apb(1, 12'h000, 32'hffff_ffff);
    apb(0, 12'h000, 0);
    check(rd, 32'hff04_3e00);
    apb(1, 12'h000, 0);
    apb(1, 12'h004, 32'hffff_ffff);
    apb(0, 12'h004, 0);
    check(rd, 32'hff04_3e00);
    apb(1, 12'h004, 0);
    apb(0, 12'h010, 0);
    check({rd[30:0], er}, 32'h1);
  endtask
  task mul(input logic p, input logic f, input logic n, input logic z);
    @(posedge clk_sys_i);
    op_pe_i <= p;
    mul_op_i <= 1;
    mul_float_i <= f;
    mul_nan_i <= n;
    mul_inf_zero_i <= z;
    go;
  endtask
  task t_mul;
    mul(0, 1, 1, 0);
    check({sx[9], mult_invalid_sticky_x_o}, 2'h3);
    mul(0, 0, 0, 0);
    check(sx[9], 1);
    mul(0, 1, 0, 0);
    check({sx[9], mult_invalid_sticky_x_o}, 2'h1);
    mul(1, 1, 0, 1);
    check({pe_y_arith_status_o[9], mult_invalid_sticky_y_o}, 2'h3);
    apb(0, 12'h00c, 0);
    check(rd, 32'h200);
    apb(0, 12'h008, 0);
    check(rd, 32'h200);
    apb(1, 12'h008, 0);
    check(mult_invalid_sticky_x_o, 0);
    apb(1, 12'h00c, 0);
    check(mult_invalid_sticky_y_o, 0);
  endtask
  task t_alu;
    logic [7:0] h;
    h = 0;
    for (int i = 0; i < 11; i++) begin
      @(posedge clk_sys_i);
      op_pe_i <= 0;
      alu_op_i <= 1;
      alu_float_i <= i[0];
      alu_cmp_i <= (i != 10);
      alu_cmp_x_gt_i <= i[1] ^ i[0];
      if (i != 10) h = {i[1] ^ i[0], h[7:1]};
      go;
      check(sx[10], i[0]);
      check(sx[31:24], h);
    end
  endtask
  task sh(input logic [2:0] k, input logic [7:0] p, input logic [7:0] l,
          input logic [5:0] c, input logic lost, input logic [31:0] a,
          input logic [31:0] r, input logic [2:0] e);
    @(posedge clk_sys_i);
    op_pe_i <= 0;
    sh_op_i <= 1;
    sh_kind_i <= k;
    sh_pos_i <= p;
    sh_len_i <= l;
    sh_lead_cnt_i <= c;
    sh_lost_bits_i <= lost;
    sh_in_i <= a;
    sh_result_i <= r;
    go;
    check(sx[13:11], e);
  endtask
  task bt(input logic [31:0] s, input logic [31:0] v, input logic e);
    @(posedge clk_sys_i);
    op_pe_i <= 1;
    bt_op_i <= 1;
    bt_sysreg_i <= s;
    bt_value_i <= v;
    go;
    check(pe_y_arith_status_o[18], e);
  endtask
  initial begin
    repeat (6) @(posedge clk_sys_i);
    reset_i <= 0;
    t_reg;
    t_mul;
    t_alu;
    sh(0, 0, 0, 0, 1, 32'h4000_0000, 32'h1, 3'h1);
    sh(0, 0, 0, 0, 0, 32'h8000_0001, 32'h0, 3'h6);
    sh(1, 8'h28, 0, 0, 0, 32'h5, 32'h5, 3'h3);
    sh(1, 8'h03, 0, 0, 0, 32'h8, 32'h8, 3'h0);
    sh(2, 8'h20, 0, 0, 0, 32'h0, 32'h1, 3'h1);
    sh(3, 8'h1e, 8'h04, 0, 0, 32'h1, 32'h1, 3'h1);
    sh(3, 8'h1c, 8'h04, 0, 0, 32'h1, 32'h1, 3'h0);
    sh(4, 0, 0, 6'h20, 0, 32'h0, 32'h20, 3'h1);
    sh(4, 0, 0, 6'h1f, 0, 32'h1, 32'h1f, 3'h0);
    bt(32'hf0, 32'h30, 1);
    bt(32'hf0, 32'h0f, 0);
    final_report;
  end
endmodule
bind asfu_flags_top asfu_flags_sva chk (.*);
